// file: logic/mpp_pkg.sv
// Constants and types shared by the multiplexed port pin block
package mpp_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ****************************************************************
  // Port widths
  // ****************************************************************
  localparam int P9_W  = 7;
  localparam int P10_W = 8;
  localparam int P11_W = 8;
  localparam int P12_W = 8;
  localparam int P13_W = 7;
  localparam int P14_W = 4;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [APB_AW-1:0] PORT9_BASE    = 8'h00;
  localparam logic [APB_AW-1:0] PORT10_BASE   = 8'h10;
  localparam logic [APB_AW-1:0] PORT11_BASE   = 8'h20;
  localparam logic [APB_AW-1:0] PORT12_BASE   = 8'h30;
  localparam logic [APB_AW-1:0] PORT13_BASE   = 8'h40;
  localparam logic [APB_AW-1:0] PORT14_BASE   = 8'h50;
  localparam logic [APB_AW-1:0] PORT_MASK     = 8'hF0;
  localparam logic [APB_AW-1:0] OFS_MASK      = 8'h0F;
  localparam logic [APB_AW-1:0] OFS_DATA      = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DIR       = 8'h04;
  localparam logic [APB_AW-1:0] OFS_FSEL      = 8'h08;
  localparam logic [APB_AW-1:0] SER_CTRL_ADDR = 8'h60;
  localparam logic [APB_AW-1:0] STBY_ADDR     = 8'h64;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SER_CTRL_MASTER_BIT = 0;
  localparam int SER_CTRL_SERIAL_BIT = 1;
  localparam int STBY_MODE_LSB       = 0;
  localparam int SER_RX_PIN          = 0;
  localparam int SER_TX_PIN          = 1;
  localparam int SER_CLK_PIN         = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic DIR_RESET_BIT  = 1'b1;
  localparam logic FSEL_RESET_BIT = 1'b0;
  localparam logic DATA_RESET_BIT = 1'b0;
  localparam logic SYNC_RESET_BIT = 1'b0;
  localparam logic SER_IDLE_BIT   = 1'b1;
  localparam logic [1:0] SER_CTRL_RESET = 2'h0;
  localparam logic [APB_DW-1:0] RDATA_RESET = 32'h00000000;

  // ****************************************************************
  // Standby modes
  // ****************************************************************
  typedef enum logic [1:0]
  {
    MPP_RUN   = 2'b00,
    MPP_HALT  = 2'b01,
    MPP_WATCH = 2'b10,
    MPP_STOP  = 2'b11
  } mpp_standby_e;

endpackage

// file: logic/mpp_port_slice.sv
// One port: data latch, direction, function select and pin mux
`timescale 1ns/100ps
module mpp_port_slice #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Register writes
  input  wire logic         wr_data_in,
  input  wire logic         wr_dir_in,
  input  wire logic         wr_fsel_in,
  input  wire logic [W-1:0] wdata_in,
  // Alternate function
  input  wire logic [W-1:0] alt_out_in,
  input  wire logic [W-1:0] alt_oe_in,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out,
  // Register reads
  output logic      [W-1:0] rd_data_out,
  output logic      [W-1:0] dir_out,
  output logic      [W-1:0] fsel_out,
  output logic      [W-1:0] pin_sync_out
);
  import mpp_pkg::*;

  logic [W-1:0] latch_ff;
  logic [W-1:0] dir_ff;
  logic [W-1:0] fsel_ff;

  mpp_sync #(.W(W)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (pin_in),
    .q_out    (pin_sync_out)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      latch_ff <= {W{DATA_RESET_BIT}};
      dir_ff   <= {W{DIR_RESET_BIT}};
      fsel_ff  <= {W{FSEL_RESET_BIT}};
    end
    else
    begin
      if (wr_data_in)
        latch_ff <= wdata_in;
      if (wr_dir_in)
        dir_ff <= wdata_in;
      if (wr_fsel_in)
        fsel_ff <= wdata_in;
    end
  end

  // ****************************************************************
  // Per-pin mux
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_pin
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          pin_out[i]    <= DATA_RESET_BIT;
          pin_oe_out[i] <= 1'b0;
        end
        else if (fsel_ff[i])
        begin
          pin_out[i]    <= alt_out_in[i];
          pin_oe_out[i] <= alt_oe_in[i];
        end
        else
        begin
          pin_out[i]    <= latch_ff[i];
          pin_oe_out[i] <= ~dir_ff[i];
        end
      end
      // Output pins read back the latch, inputs the pin level
      assign rd_data_out[i] = dir_ff[i] ? pin_sync_out[i]
                                        : latch_ff[i];
    end
  endgenerate

  assign dir_out  = dir_ff;
  assign fsel_out = fsel_ff;

endmodule // mpp_port_slice

// file: logic/mpp_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module mpp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  import mpp_pkg::*;

  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_ff <= {W{SYNC_RESET_BIT}};
      q_out   <= {W{SYNC_RESET_BIT}};
    end
    else
    begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule // mpp_sync

// file: logic/mpp_top.sv
// Ports 9 to 14 with function multiplexing, APB registers and reset
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module mpp_top
(
  // Clock and reset
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        ARST_N_IN,
  // APB slave
  input  wire logic                        PSEL_IN,
  input  wire logic                        PENABLE_IN,
  input  wire logic                        PWRITE_IN,
  input  wire logic [mpp_pkg::APB_AW-1:0]  PADDR_IN,
  input  wire logic [mpp_pkg::APB_DW-1:0]  PWDATA_IN,
  output logic      [mpp_pkg::APB_DW-1:0]  PRDATA_OUT,
  output logic                             PREADY_OUT,
  output logic                             PSLVERR_OUT,
  // Port 9 pins
  input  wire logic [mpp_pkg::P9_W-1:0]    P9_PIN_IN,
  output logic      [mpp_pkg::P9_W-1:0]    P9_PIN_OUT,
  output logic      [mpp_pkg::P9_W-1:0]    P9_PIN_OE_OUT,
  // Port 10 pins
  input  wire logic [mpp_pkg::P10_W-1:0]   P10_PIN_IN,
  output logic      [mpp_pkg::P10_W-1:0]   P10_PIN_OUT,
  output logic      [mpp_pkg::P10_W-1:0]   P10_PIN_OE_OUT,
  // Port 11 pins
  input  wire logic [mpp_pkg::P11_W-1:0]   P11_PIN_IN,
  output logic      [mpp_pkg::P11_W-1:0]   P11_PIN_OUT,
  output logic      [mpp_pkg::P11_W-1:0]   P11_PIN_OE_OUT,
  // Port 12 pins
  input  wire logic [mpp_pkg::P12_W-1:0]   P12_PIN_IN,
  output logic      [mpp_pkg::P12_W-1:0]   P12_PIN_OUT,
  output logic      [mpp_pkg::P12_W-1:0]   P12_PIN_OE_OUT,
  // Port 13 pins
  input  wire logic [mpp_pkg::P13_W-1:0]   P13_PIN_IN,
  output logic      [mpp_pkg::P13_W-1:0]   P13_PIN_OUT,
  output logic      [mpp_pkg::P13_W-1:0]   P13_PIN_OE_OUT,
  // Port 14 pins
  input  wire logic [mpp_pkg::P14_W-1:0]   P14_PIN_IN,
  output logic      [mpp_pkg::P14_W-1:0]   P14_PIN_OUT,
  output logic      [mpp_pkg::P14_W-1:0]   P14_PIN_OE_OUT,
  // LCD segment engine
  input  wire logic [mpp_pkg::P9_W-1:0]    LCD_SEG_A_IN,
  input  wire logic [mpp_pkg::P13_W-1:0]   LCD_SEG_B_IN,
  input  wire logic [mpp_pkg::P14_W-1:0]   LCD_SEG_C_IN,
  // Meter PWM engine
  input  wire logic [mpp_pkg::P10_W-1:0]   METER_PWM_A_IN,
  input  wire logic [mpp_pkg::P11_W-1:0]   METER_PWM_B_IN,
  input  wire logic [mpp_pkg::P12_W-1:0]   METER_PWM_C_IN,
  // Clocked serial channel 2 engine
  input  wire logic                        SERIAL2_TX_IN,
  input  wire logic                        SERIAL2_CLK_IN,
  output logic                             SERIAL2_RX_OUT,
  output logic                             SERIAL2_CLK_OUT,
  output logic                             SERIAL2_MASTER_OUT,
  // Standby
  output logic      [1:0]                  STANDBY_MODE_OUT
);
  import mpp_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_n;

  // Assertion is immediate, release is clocked to avoid recovery races
  mpp_sync #(.W(1)) u_rst_sync (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (ARST_N_IN),
    .d_in     (1'b1),
    .q_out    (rst_n)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic                     setup_ph;
  logic                     wr_en;
  logic [APB_AW-1:0]        port_sel;
  logic [APB_AW-1:0]        reg_ofs;
  logic                     ofs_ok;
  logic [5:0]               port_hit;
  logic [5:0]               wr_data_v;
  logic [5:0]               wr_dir_v;
  logic [5:0]               wr_fsel_v;
  logic                     hit_ser;
  logic                     hit_stby;
  logic                     mapped;
  logic [APB_DW-1:0]        nxt_rdata;

  assign setup_ph = PSEL_IN & ~PENABLE_IN;
  assign wr_en    = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  assign port_sel = PADDR_IN & PORT_MASK;
  assign reg_ofs  = PADDR_IN & OFS_MASK;
  assign ofs_ok   = (reg_ofs == OFS_DATA) | (reg_ofs == OFS_DIR)
                  | (reg_ofs == OFS_FSEL);
  assign port_hit[0] = ofs_ok & (port_sel == PORT9_BASE);
  assign port_hit[1] = ofs_ok & (port_sel == PORT10_BASE);
  assign port_hit[2] = ofs_ok & (port_sel == PORT11_BASE);
  assign port_hit[3] = ofs_ok & (port_sel == PORT12_BASE);
  assign port_hit[4] = ofs_ok & (port_sel == PORT13_BASE);
  assign port_hit[5] = ofs_ok & (port_sel == PORT14_BASE);
  assign hit_ser  = (PADDR_IN == SER_CTRL_ADDR);
  assign hit_stby = (PADDR_IN == STBY_ADDR);
  assign mapped   = (|port_hit) | hit_ser | hit_stby;

  genvar p;
  generate
    for (p = 0; p < 6; p++)
    begin : g_wr
      assign wr_data_v[p] = wr_en & port_hit[p] & (reg_ofs == OFS_DATA);
      assign wr_dir_v[p]  = wr_en & port_hit[p] & (reg_ofs == OFS_DIR);
      assign wr_fsel_v[p] = wr_en & port_hit[p] & (reg_ofs == OFS_FSEL);
    end
  endgenerate

  // ****************************************************************
  // Serial and standby control
  // ****************************************************************
  logic [1:0]    ser_ctrl_ff;
  mpp_standby_e  stby_ff;
  mpp_standby_e  nxt_stby;
  logic          ser_master;
  logic          ser_on;

  assign ser_master = ser_ctrl_ff[SER_CTRL_MASTER_BIT];
  assign ser_on     = ser_ctrl_ff[SER_CTRL_SERIAL_BIT];

  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      ser_ctrl_ff <= SER_CTRL_RESET;
    else if (wr_en & hit_ser)
      ser_ctrl_ff <= PWDATA_IN[1:0];
  end

  always_comb
  begin
    nxt_stby = stby_ff;
    if (wr_en & hit_stby)
    begin
      case (PWDATA_IN[STBY_MODE_LSB +: 2])
        2'b00:   nxt_stby = MPP_RUN;
        2'b01:   nxt_stby = MPP_HALT;
        2'b10:   nxt_stby = MPP_WATCH;
        2'b11:   nxt_stby = MPP_STOP;
        default: nxt_stby = MPP_RUN;
      endcase
    end
  end

  // Reset or an APB write of MPP_RUN wakes the block here; other wake sources live elsewhere
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      stby_ff <= MPP_RUN;
    else
      stby_ff <= nxt_stby;
  end

  assign STANDBY_MODE_OUT = stby_ff;

  // ****************************************************************
  // Port slices
  // ****************************************************************
  logic [P9_W-1:0]  rd9,  dir9,  fs9,  sy9;
  logic [P10_W-1:0] rd10, dir10, fs10, sy10;
  logic [P11_W-1:0] rd11, dir11, fs11, sy11;
  logic [P12_W-1:0] rd12, dir12, fs12, sy12;
  logic [P13_W-1:0] rd13, dir13, fs13, sy13;
  logic [P14_W-1:0] rd14, dir14, fs14, sy14;
  logic [P14_W-1:0] alt14_out;
  logic [P14_W-1:0] alt14_oe;

  mpp_port_slice #(.W(P9_W)) u_p9 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[0]),
    .wr_dir_in    (wr_dir_v[0]),
    .wr_fsel_in   (wr_fsel_v[0]),
    .wdata_in     (PWDATA_IN[P9_W-1:0]),
    .alt_out_in   (LCD_SEG_A_IN),
    .alt_oe_in    ({P9_W{1'b1}}),
    .pin_in       (P9_PIN_IN),
    .pin_out      (P9_PIN_OUT),
    .pin_oe_out   (P9_PIN_OE_OUT),
    .rd_data_out  (rd9),
    .dir_out      (dir9),
    .fsel_out     (fs9),
    .pin_sync_out (sy9)
  );

  mpp_port_slice #(.W(P10_W)) u_p10 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[1]),
    .wr_dir_in    (wr_dir_v[1]),
    .wr_fsel_in   (wr_fsel_v[1]),
    .wdata_in     (PWDATA_IN[P10_W-1:0]),
    .alt_out_in   (METER_PWM_A_IN),
    .alt_oe_in    ({P10_W{1'b1}}),
    .pin_in       (P10_PIN_IN),
    .pin_out      (P10_PIN_OUT),
    .pin_oe_out   (P10_PIN_OE_OUT),
    .rd_data_out  (rd10),
    .dir_out      (dir10),
    .fsel_out     (fs10),
    .pin_sync_out (sy10)
  );

  mpp_port_slice #(.W(P11_W)) u_p11 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[2]),
    .wr_dir_in    (wr_dir_v[2]),
    .wr_fsel_in   (wr_fsel_v[2]),
    .wdata_in     (PWDATA_IN[P11_W-1:0]),
    .alt_out_in   (METER_PWM_B_IN),
    .alt_oe_in    ({P11_W{1'b1}}),
    .pin_in       (P11_PIN_IN),
    .pin_out      (P11_PIN_OUT),
    .pin_oe_out   (P11_PIN_OE_OUT),
    .rd_data_out  (rd11),
    .dir_out      (dir11),
    .fsel_out     (fs11),
    .pin_sync_out (sy11)
  );

  mpp_port_slice #(.W(P12_W)) u_p12 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[3]),
    .wr_dir_in    (wr_dir_v[3]),
    .wr_fsel_in   (wr_fsel_v[3]),
    .wdata_in     (PWDATA_IN[P12_W-1:0]),
    .alt_out_in   (METER_PWM_C_IN),
    .alt_oe_in    ({P12_W{1'b1}}),
    .pin_in       (P12_PIN_IN),
    .pin_out      (P12_PIN_OUT),
    .pin_oe_out   (P12_PIN_OE_OUT),
    .rd_data_out  (rd12),
    .dir_out      (dir12),
    .fsel_out     (fs12),
    .pin_sync_out (sy12)
  );

  mpp_port_slice #(.W(P13_W)) u_p13 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[4]),
    .wr_dir_in    (wr_dir_v[4]),
    .wr_fsel_in   (wr_fsel_v[4]),
    .wdata_in     (PWDATA_IN[P13_W-1:0]),
    .alt_out_in   (LCD_SEG_B_IN),
    .alt_oe_in    ({P13_W{1'b1}}),
    .pin_in       (P13_PIN_IN),
    .pin_out      (P13_PIN_OUT),
    .pin_oe_out   (P13_PIN_OE_OUT),
    .rd_data_out  (rd13),
    .dir_out      (dir13),
    .fsel_out     (fs13),
    .pin_sync_out (sy13)
  );

  // Port 14 control mode: LCD segments, except pins 0 to 2 while the serial channel owns them
  always_comb
  begin
    alt14_out = LCD_SEG_C_IN;
    alt14_oe  = {P14_W{1'b1}};
    if (ser_on)
    begin
      alt14_oe[SER_RX_PIN]   = 1'b0;
      alt14_out[SER_TX_PIN]  = SERIAL2_TX_IN;
      alt14_out[SER_CLK_PIN] = SERIAL2_CLK_IN;
      alt14_oe[SER_CLK_PIN]  = ser_master;
    end
  end

  mpp_port_slice #(.W(P14_W)) u_p14 (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (rst_n),
    .wr_data_in   (wr_data_v[5]),
    .wr_dir_in    (wr_dir_v[5]),
    .wr_fsel_in   (wr_fsel_v[5]),
    .wdata_in     (PWDATA_IN[P14_W-1:0]),
    .alt_out_in   (alt14_out),
    .alt_oe_in    (alt14_oe),
    .pin_in       (P14_PIN_IN),
    .pin_out      (P14_PIN_OUT),
    .pin_oe_out   (P14_PIN_OE_OUT),
    .rd_data_out  (rd14),
    .dir_out      (dir14),
    .fsel_out     (fs14),
    .pin_sync_out (sy14)
  );

  // ****************************************************************
  // Serial engine returns
  // ****************************************************************
  // Idle high so the engine sees no false edge while unrouted
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SERIAL2_RX_OUT     <= SER_IDLE_BIT;
      SERIAL2_CLK_OUT    <= SER_IDLE_BIT;
      SERIAL2_MASTER_OUT <= 1'b0;
    end
    else
    begin
      SERIAL2_RX_OUT  <= (ser_on & fs14[SER_RX_PIN])
                         ? sy14[SER_RX_PIN] : SER_IDLE_BIT;
      SERIAL2_CLK_OUT <= (ser_on & fs14[SER_CLK_PIN] & ~ser_master)
                         ? sy14[SER_CLK_PIN] : SER_IDLE_BIT;
      SERIAL2_MASTER_OUT <= ser_master;
    end
  end

  // ****************************************************************
  // Read mux and APB answer
  // ****************************************************************
  function automatic logic [APB_DW-1:0] pick(
    input logic [APB_AW-1:0] ofs,
    input logic [7:0]        d,
    input logic [7:0]        r,
    input logic [7:0]        f
  );
    logic [APB_DW-1:0] v;
    v = RDATA_RESET;
    if (ofs == OFS_DATA)
      v[7:0] = d;
    else if (ofs == OFS_DIR)
      v[7:0] = r;
    else if (ofs == OFS_FSEL)
      v[7:0] = f;
    return v;
  endfunction

  always_comb
  begin
    nxt_rdata = RDATA_RESET;
    if (port_hit[0])
      nxt_rdata = pick(reg_ofs, {1'b0, rd9}, {1'b0, dir9}, {1'b0, fs9});
    else if (port_hit[1])
      nxt_rdata = pick(reg_ofs, rd10, dir10, fs10);
    else if (port_hit[2])
      nxt_rdata = pick(reg_ofs, rd11, dir11, fs11);
    else if (port_hit[3])
      nxt_rdata = pick(reg_ofs, rd12, dir12, fs12);
    else if (port_hit[4])
      nxt_rdata = pick(reg_ofs, {1'b0, rd13}, {1'b0, dir13},
                       {1'b0, fs13});
    else if (port_hit[5])
      nxt_rdata = pick(reg_ofs, {4'h0, rd14}, {4'h0, dir14},
                       {4'h0, fs14});
    else if (hit_ser)
      nxt_rdata[1:0] = ser_ctrl_ff;
    else if (hit_stby)
      nxt_rdata[STBY_MODE_LSB +: 2] = stby_ff;
  end

  // Read data is captured in setup so the access phase never waits
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PRDATA_OUT  <= RDATA_RESET;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      PREADY_OUT  <= setup_ph;
      PSLVERR_OUT <= setup_ph & ~mapped;
      if (setup_ph)
        PRDATA_OUT <= PWRITE_IN ? RDATA_RESET : nxt_rdata;
    end
  end

endmodule // mpp_top

// file: tb/mpp_assertions.sv
// Port-level checks for the multiplexed port pin block
`timescale 1ns/100ps
module mpp_assertions
(
  // Clock, reset and bus
  input wire logic        REF_CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // Pins and side outputs
  input wire logic [6:0]  P9_PIN_OE_OUT,
  input wire logic [3:0]  P14_PIN_OE_OUT,
  input wire logic        SERIAL2_CLK_OUT,
  input wire logic        SERIAL2_MASTER_OUT,
  input wire logic [1:0]  STANDBY_MODE_OUT
);
  import mpp_pkg::*;
  wire       setup = PSEL_IN && !PENABLE_IN;
  wire       wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  wire [1:0] wd = PWDATA_IN[1:0];
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  rst_idle_a: assert property (
    $rose(ARST_N_IN) |-> !P9_PIN_OE_OUT && !P14_PIN_OE_OUT
    && !STANDBY_MODE_OUT) else $error("pins or standby live after reset");
  ready_access_a: assert property (setup |=> PREADY_OUT)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  err_unmapped_a: assert property (
    setup && PADDR_IN >= 8'h68 |=> PREADY_OUT && PSLVERR_OUT)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (
    setup && PADDR_IN == STBY_ADDR |=> !PSLVERR_OUT)
    else $error("mapped access refused");
  stby_wr_a: assert property (
    wr && PADDR_IN == STBY_ADDR |=> STANDBY_MODE_OUT == $past(wd))
    else $error("standby mode not written");
  master_wr_a: assert property (
    wr && PADDR_IN == SER_CTRL_ADDR
    |=> ##1 {1'b0, SERIAL2_MASTER_OUT} == ($past(wd, 2) & 2'h1))
    else $error("master bit not written");
  clk_master_a: assert property (
    SERIAL2_MASTER_OUT [*3] |-> SERIAL2_CLK_OUT)
    else $error("shift clock taken in while master");
endmodule // mpp_assertions

bind mpp_top mpp_assertions chk (.*);

// file: tb/mpp_engines.sv
// Stand-in for the LCD, meter and serial engines beside the ports
`timescale 1ns/100ps
module mpp_engines
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Engine lines, ports 9 to 14 packed in order
  output logic      [41:0] alt_out,
  output logic             tx_out,
  output logic             clk_out
);
  logic [5:0] step_ff;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      step_ff <= 6'h00;
    else
      step_ff <= step_ff + 6'h01;
  end

  // Lines follow a counter, so a stale or swapped pin shows up
  assign alt_out = {7{step_ff}} ^ 42'h2D2C3A59E6A;
  assign tx_out  = step_ff[0];
  // Shift clock idles high between bursts
  assign clk_out = step_ff[1] | step_ff[5];
endmodule // mpp_engines

// file: tb/tb_top.sv
// Self-checking bench for the multiplexed port pin block
`timescale 1ns/100ps
module tb_top;
  import mpp_pkg::*;
  logic        REF_CLK_IN = 1'b0;
  logic        ARST_N_IN = 1'b0;
  logic        PSEL_IN = 1'b0;
  logic        PENABLE_IN = 1'b0;
  logic        PWRITE_IN = 1'b0;
  logic [7:0]  PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd, m, pin;
  logic        PREADY_OUT, PSLVERR_OUT, er;
  logic [6:0]  P9_PIN_IN, P9_PIN_OUT, P9_PIN_OE_OUT, LCD_SEG_A_IN;
  logic [7:0]  P10_PIN_IN, P10_PIN_OUT, P10_PIN_OE_OUT, METER_PWM_A_IN;
  logic [7:0]  P11_PIN_IN, P11_PIN_OUT, P11_PIN_OE_OUT, METER_PWM_B_IN;
  logic [7:0]  P12_PIN_IN, P12_PIN_OUT, P12_PIN_OE_OUT, METER_PWM_C_IN;
  logic [6:0]  P13_PIN_IN, P13_PIN_OUT, P13_PIN_OE_OUT, LCD_SEG_B_IN;
  logic [3:0]  P14_PIN_IN, P14_PIN_OUT, P14_PIN_OE_OUT, LCD_SEG_C_IN;
  logic        SERIAL2_TX_IN, SERIAL2_CLK_IN, SERIAL2_RX_OUT;
  logic        SERIAL2_CLK_OUT, SERIAL2_MASTER_OUT;
  logic [1:0]  STANDBY_MODE_OUT;
  logic [43:0] prev;
  logic [41:0] alt, pout, poe;
  logic [41:0] drv = 42'h2D2C3A59E6A;
  logic [7:0]  b;
  int          failures = 0;
  int          checked = 0;
  int          lo [6] = '{35, 27, 19, 11, 4, 0};
  int          pw [6] = '{P9_W, P10_W, P11_W, P12_W, P13_W, P14_W};

  assign {LCD_SEG_A_IN, METER_PWM_A_IN, METER_PWM_B_IN, METER_PWM_C_IN,
          LCD_SEG_B_IN, LCD_SEG_C_IN} = alt;
  assign pout = {P9_PIN_OUT, P10_PIN_OUT, P11_PIN_OUT, P12_PIN_OUT,
                 P13_PIN_OUT, P14_PIN_OUT};
  assign poe = {P9_PIN_OE_OUT, P10_PIN_OE_OUT, P11_PIN_OE_OUT,
                P12_PIN_OE_OUT, P13_PIN_OE_OUT, P14_PIN_OE_OUT};
  // Wire level: a driven pin shows the block's value, else the bench's
  assign {P9_PIN_IN, P10_PIN_IN, P11_PIN_IN, P12_PIN_IN, P13_PIN_IN,
          P14_PIN_IN} = poe & pout | ~poe & drv;

  mpp_top DUT (.*);
  mpp_engines ENG (.clk_in(REF_CLK_IN), .rst_n_in(ARST_N_IN), .alt_out(alt),
                   .tx_out(SERIAL2_TX_IN), .clk_out(SERIAL2_CLK_IN));

  initial
  begin
    forever #50 REF_CLK_IN = ~REF_CLK_IN;
  end

  always @(posedge REF_CLK_IN)
    prev <= {alt, SERIAL2_TX_IN, SERIAL2_CLK_IN};

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One transfer; an idle cycle first keeps the strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge REF_CLK_IN);
    PENABLE_IN <= 1'b1;
    do
    begin
      @(posedge REF_CLK_IN);
      n++;
    end
    while (PREADY_OUT !== 1'b1 && n < 20);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    if (PREADY_OUT !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", rd, exp);
  endtask

  initial
  begin
    repeat (10) @(posedge REF_CLK_IN);
    ARST_N_IN <= 1'b1;
    repeat (3) @(posedge REF_CLK_IN);
    chk("oe after reset", poe, 42'h0);
    // ************************************************
    // Port mode, one port at a time
    // ************************************************
    for (int i = 0; i < 6; i++)
    begin
      b = PORT9_BASE + 8'(16 * i);
      m = (32'h1 << pw[i]) - 32'h1;
      pin = 32'(drv >> lo[i]);
      rdc(b + OFS_DIR, m);
      rdc(b + OFS_FSEL, 32'h0);
      apb(1'b1, b + OFS_DATA, 32'hFFFFFFA5);
      apb(1'b1, b + OFS_DIR, 32'h55);
      rdc(b + OFS_DIR, 32'h55 & m);
      rdc(b + OFS_DATA, (32'hA0 | pin & 32'h55) & m);
      chk("oe", (poe >> lo[i]) & m, 32'hAA & m);
      chk("out", (pout >> lo[i]) & 32'hAA & m, 32'hA0 & m);
      apb(1'b1, b + OFS_FSEL, 32'hFF);
      rdc(b + OFS_FSEL, m);
    end
    repeat (2) @(posedge REF_CLK_IN);
    chk("control pins", pout, prev[43:2]);
    chk("control oe", poe, {42{1'b1}});
    apb(1'b1, SER_CTRL_ADDR, 32'h3);
    repeat (2) @(posedge REF_CLK_IN);
    chk("serial oe", P14_PIN_OE_OUT, 4'hE);
    chk("serial out", P14_PIN_OUT[2:1], {prev[0], prev[1]});
    for (int v = 0; v < 2; v++)
    begin
      drv[0] <= v[0];
      drv[2] <= v[0];
      repeat (4) @(posedge REF_CLK_IN);
      chk("serial rx", SERIAL2_RX_OUT, v[0]);
    end
    apb(1'b1, SER_CTRL_ADDR, 32'h2);
    drv[2] <= 1'b0;
    // Pin enable drops one edge late, then three edges to the clock return
    repeat (5) @(posedge REF_CLK_IN);
    chk("slave oe", P14_PIN_OE_OUT, 4'hA);
    chk("slave clock", SERIAL2_CLK_OUT, 1'b0);
    apb(1'b1, 8'h70, 32'hFFFFFFFF);
    chk("refused write", er, 1'b1);
    rdc(8'h70, 32'h0);
    for (int k = 1; k < 4; k++)
    begin
      apb(1'b1, STBY_ADDR, 32'(k));
      rdc(STBY_ADDR, 32'(k));
    end
    ARST_N_IN <= 1'b0;
    // Looked at well before the next edge, so only an async reset passes
    #10 chk("reset", {STANDBY_MODE_OUT, poe}, 44'h0);
    repeat (10) @(posedge REF_CLK_IN);
    ARST_N_IN <= 1'b1;
    repeat (3) @(posedge REF_CLK_IN);
    rdc(PORT14_BASE + OFS_DIR, 32'hF);
    rdc(PORT14_BASE + OFS_FSEL, 32'h0);
    wrap_up();
  end
endmodule // tb_top
